// ---- rtl/hph_pkg.sv ----
// Shared constants and types for the host port handshake
package hph_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 10;
    // Strobe low and high least widths, in CPU periods
    localparam int unsigned STB_LOW_P      = 4;
    localparam int unsigned STB_HIGH_P     = 4;
    localparam int unsigned STB_LOW_CYC    = STB_LOW_P;
    localparam int unsigned STB_HIGH_CYC   = STB_HIGH_P;
    // Data valid before ready low, in CPU periods
    localparam int unsigned DATA_LEAD_CYC  = 2;
    // Internal completion latency of the transfer engine
    localparam logic [3:0]  XFER_LAT_CYC   = 4'h6;
    // Access select encodings
    localparam logic [1:0]  SEL_CONTROL    = 2'h0;
    localparam logic [1:0]  SEL_WIN_INC    = 2'h1;
    localparam logic [1:0]  SEL_ADDRESS    = 2'h2;
    localparam logic [1:0]  SEL_WIN_FIXED  = 2'h3;
    // Reset strap bit positions on the data bus
    localparam int unsigned STRAP_ENDIAN_BIT = 8;
    localparam int unsigned STRAP_BOOT_HI    = 4;
    localparam int unsigned STRAP_BOOT_LO    = 3;
    localparam logic [15:0] CONTROL_RESET  = 16'h0000;
    localparam logic [31:0] ADDRESS_RESET  = 32'h00000000;

    typedef enum logic [1:0] {
        HPH_IDLE   = 2'b00,
        HPH_ACTIVE = 2'b01,
        HPH_FETCH  = 2'b10,
        HPH_DONE   = 2'b11
    } hph_dev_state_t;

    typedef enum logic [2:0] {
        HPH_H_IDLE  = 3'b000,
        HPH_H_SETUP = 3'b001,
        HPH_H_LOW   = 3'b010,
        HPH_H_WAIT  = 3'b011,
        HPH_H_HIGH  = 3'b100
    } hph_host_state_t;
endpackage

// ---- rtl/hph_if.sv ----
// Parallel host port pins between host and device
`timescale 1ns/100ps
`default_nettype none
interface hph_if;
    logic        port_select_n;
    logic        data_strobe_one;
    logic        data_strobe_two;
    logic        port_ready_n;
    logic [1:0]  access_select;
    logic        read_not_write;
    logic        halfword_select;
    logic [15:0] host_data_dev_o;
    logic        host_data_dev_oe_n;
    logic [15:0] host_data_host_o;
    logic        host_data_host_oe_n;
    logic [15:0] host_data_bus;

    assign host_data_bus = !host_data_dev_oe_n  ? host_data_dev_o  :
                           !host_data_host_oe_n ? host_data_host_o :
                           16'h0000;

    modport dev (
        input  port_select_n, data_strobe_one, data_strobe_two,
        input  access_select, read_not_write, halfword_select,
        input  host_data_bus,
        output port_ready_n, host_data_dev_o, host_data_dev_oe_n
    );
    modport host (
        output port_select_n, data_strobe_one, data_strobe_two,
        output access_select, read_not_write, halfword_select,
        output host_data_host_o, host_data_host_oe_n,
        input  port_ready_n, host_data_bus
    );
endinterface
`default_nettype wire

// ---- rtl/hph_device.sv ----
// Device end of the host port handshake
`timescale 1ns/100ps
`default_nettype none
module hph_device
    import hph_pkg::*;
(
    input  wire logic   mclk,
    input  wire logic   rst,
    hph_if.dev          pins,
    output logic        xfer_req,
    output logic        xfer_write,
    output logic [31:0] xfer_addr,
    output logic [31:0] xfer_wdata,
    input  wire logic   xfer_done,
    input  wire logic [31:0] xfer_rdata,
    output logic        strap_endian,
    output logic [1:0]  strap_boot,
    output logic [15:0] control_word
);
    logic [2:0]  sync_a;
    logic [2:0]  sync_b;
    logic [3:0]  sel_a;
    logic [3:0]  sel_b;
    logic [15:0] bus_a;
    logic [15:0] bus_b;
    logic        strobe_q;
    hph_dev_state_t state;
    hph_dev_state_t next_state;
    logic        busy;
    logic        next_busy;
    logic        ready_n;
    logic        next_ready_n;
    logic [1:0]  sel;
    logic [1:0]  next_sel;
    logic        rnw;
    logic        next_rnw;
    logic        half;
    logic        next_half;
    logic [31:0] window;
    logic [31:0] next_window;
    logic [31:0] addr;
    logic [31:0] next_addr;
    logic [15:0] ctrl;
    logic [15:0] next_ctrl;
    logic [15:0] dout;
    logic [15:0] next_dout;
    logic        oe_n;
    logic        next_oe_n;
    logic        req;
    logic        next_req;
    logic        wr;
    logic        next_wr;
    logic        lead;
    logic        next_lead;
    logic        inc;
    logic        next_inc;
    logic        strobe_n;
    logic        cs_n;
    logic        strobe_fall;
    logic        strobe_rise;
    logic        is_win;

    // Two-flop pin synchronisers
    always_ff @(posedge mclk)
    begin
        sync_a <= {pins.port_select_n, pins.data_strobe_one,
                   pins.data_strobe_two};
        sync_b <= sync_a;
        sel_a  <= {pins.access_select, pins.read_not_write,
                   pins.halfword_select};
        sel_b  <= sel_a;
        bus_a  <= pins.host_data_bus;
        bus_b  <= bus_a;
    end

    assign cs_n = sync_b[2];
    assign strobe_n    = cs_n | ~(sync_b[1] ^ sync_b[0]);
    assign strobe_fall = strobe_q & ~strobe_n;
    assign strobe_rise = ~strobe_q & strobe_n;
    assign is_win      = (sel_b[3:2] == SEL_WIN_INC) ||
                         (sel_b[3:2] == SEL_WIN_FIXED);

    always_comb
    begin
        next_state   = state;
        next_busy    = busy;
        next_sel     = sel;
        next_rnw     = rnw;
        next_half    = half;
        next_window  = window;
        next_addr    = addr;
        next_ctrl    = ctrl;
        next_dout    = dout;
        next_oe_n    = oe_n;
        next_req     = 1'b0;
        next_wr      = wr;
        next_inc     = inc;
        next_lead    = 1'b0;
        next_ready_n = 1'b0;
        // Engine completion clears busy, steps the address after an incrementing window access
        if (busy && xfer_done)
        begin
            next_busy = 1'b0;
            if (inc)
                next_addr = addr + 32'h00000004;
        end
        unique case (state)
            HPH_IDLE, HPH_DONE:
            begin
                if (strobe_fall)
                begin
                    next_sel  = sel_b[3:2];
                    next_rnw  = sel_b[1];
                    next_half = sel_b[0];
                    next_state = HPH_ACTIVE;
                    if (is_win && sel_b[1] && !sel_b[0] && !busy)
                    begin
                        next_req   = 1'b1;
                        next_wr    = 1'b0;
                        next_state = HPH_FETCH;
                    end
                    else if (sel_b[1])
                    begin
                        next_oe_n = 1'b0;
                        unique case (sel_b[3:2])
                            SEL_CONTROL: next_dout = ctrl;
                            SEL_ADDRESS: next_dout = sel_b[0] ?
                                addr[31:16] : addr[15:0];
                            default: next_dout = sel_b[0] ?
                                window[31:16] : window[15:0];
                        endcase
                    end
                end
            end
            HPH_FETCH:
            begin
                if (xfer_done)
                begin
                    next_window = xfer_rdata;
                    next_dout   = xfer_rdata[15:0];
                    next_oe_n   = 1'b0;
                    next_lead   = 1'b1;
                    next_state  = HPH_ACTIVE;
                end
            end
            HPH_ACTIVE:
            begin
                if (strobe_rise)
                begin
                    next_oe_n  = 1'b1;
                    next_state = HPH_IDLE;
                    if (!rnw)
                    begin
                        unique case (sel)
                            SEL_CONTROL: next_ctrl = bus_b;
                            SEL_ADDRESS:
                                if (half) next_addr[31:16] = bus_b;
                                else next_addr[15:0] = bus_b;
                            default:
                                if (half) next_window[31:16] = bus_b;
                                else next_window[15:0] = bus_b;
                        endcase
                    end
                    if (half && (sel == SEL_WIN_INC ||
                                 (sel == SEL_WIN_FIXED && !rnw)))
                    begin
                        next_busy  = 1'b1;
                        next_req   = 1'b1;
                        next_wr    = !rnw;
                        next_inc   = (sel == SEL_WIN_INC);
                    end
                end
            end
        endcase
        // Ready low one cycle after data
        if (next_state == HPH_FETCH || next_lead || busy || next_busy)
            next_ready_n = 1'b1;
        if (cs_n)
            next_ready_n = 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state    <= HPH_IDLE;
            busy     <= 1'b0;
            ready_n  <= 1'b0;
            sel      <= 2'h0;
            rnw      <= 1'b0;
            half     <= 1'b0;
            window   <= 32'h00000000;
            addr     <= ADDRESS_RESET;
            ctrl     <= CONTROL_RESET;
            dout     <= 16'h0000;
            oe_n     <= 1'b1;
            req      <= 1'b0;
            wr       <= 1'b0;
            lead     <= 1'b0;
            inc      <= 1'b0;
            strobe_q <= 1'b1;
        end
        else
        begin
            state    <= next_state;
            busy     <= next_busy;
            ready_n  <= next_ready_n;
            sel      <= next_sel;
            rnw      <= next_rnw;
            half     <= next_half;
            window   <= next_window;
            addr     <= next_addr;
            ctrl     <= next_ctrl;
            dout     <= next_dout;
            oe_n     <= next_oe_n;
            req      <= next_req;
            wr       <= next_wr;
            lead     <= next_lead;
            inc      <= next_inc;
            strobe_q <= strobe_n;
        end
    end

    // Straps follow the bus during reset
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            strap_endian <= bus_b[STRAP_ENDIAN_BIT];
            strap_boot   <= bus_b[STRAP_BOOT_HI:STRAP_BOOT_LO];
        end
    end

    assign pins.port_ready_n       = ready_n;
    assign pins.host_data_dev_o    = dout;
    assign pins.host_data_dev_oe_n = oe_n;
    assign xfer_req     = req;
    assign xfer_write   = wr;
    assign xfer_addr    = addr;
    assign xfer_wdata   = window;
    assign control_word = ctrl;
endmodule // hph_device
`default_nettype wire

// ---- rtl/hph_host.sv ----
// Host end of the host port handshake
`timescale 1ns/100ps
`default_nettype none
module hph_host
    import hph_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    hph_if.host              pins,
    input  wire logic        cmd_valid,
    input  wire logic [1:0]  cmd_select,
    input  wire logic        cmd_read,
    input  wire logic        cmd_half,
    input  wire logic [15:0] cmd_wdata,
    output logic             cmd_ready,
    output logic             rsp_valid,
    output logic [15:0]      rsp_data
);
    logic [1:0]  rdy_s;
    logic [15:0] bus_a;
    logic [15:0] bus_b;
    hph_host_state_t state;
    hph_host_state_t next_state;
    logic [2:0]  cnt;
    logic [2:0]  next_cnt;
    logic        cs_n;
    logic        next_cs_n;
    logic        ds;
    logic        next_ds;
    logic [3:0]  grp;
    logic [3:0]  next_grp;
    logic [15:0] wd;
    logic [15:0] next_wd;
    logic        oe_n;
    logic        next_oe_n;
    logic        rv;
    logic        next_rv;
    logic [15:0] rd;
    logic [15:0] next_rd;
    logic        crdy;
    logic        next_crdy;

    always_ff @(posedge mclk)
    begin
        rdy_s <= {rdy_s[0], pins.port_ready_n};
        bus_a <= pins.host_data_bus;
        bus_b <= bus_a;
    end

    always_comb
    begin
        next_state = state;
        next_cnt   = cnt;
        next_cs_n  = cs_n;
        next_ds    = ds;
        next_grp   = grp;
        next_wd    = wd;
        next_oe_n  = oe_n;
        next_rv    = 1'b0;
        next_rd    = rd;
        next_crdy  = 1'b0;
        unique case (state)
            HPH_H_IDLE:
                if (cmd_valid && crdy)
                begin
                    next_grp   = {cmd_select, cmd_read, cmd_half};
                    next_wd    = cmd_wdata;
                    next_oe_n  = cmd_read;
                    next_cs_n  = 1'b0;
                    next_state = HPH_H_SETUP;
                end
                else
                    next_crdy = 1'b1;
            HPH_H_SETUP:
            begin
                next_ds    = 1'b1;
                next_cnt   = 3'(STB_LOW_CYC);
                next_state = HPH_H_LOW;
            end
            HPH_H_LOW:
            begin
                if (cnt != 3'h0)
                    next_cnt = cnt - 3'h1;
                else
                    next_state = HPH_H_WAIT;
            end
            HPH_H_WAIT:
                if (!rdy_s[1])
                begin
                    next_rd    = bus_b;
                    next_rv    = grp[1];
                    next_ds    = 1'b0;
                    next_cs_n  = 1'b1;
                    next_cnt   = 3'(STB_HIGH_CYC);
                    next_state = HPH_H_HIGH;
                end
            HPH_H_HIGH:
            begin
                // Write data stays one cycle past the strobe
                next_oe_n = 1'b1;
                if (cnt != 3'h0)
                    next_cnt = cnt - 3'h1;
                else
                    next_state = HPH_H_IDLE;
            end
            default:
                next_state = HPH_H_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state <= HPH_H_IDLE;
            cnt   <= 3'h0;
            cs_n  <= 1'b1;
            ds    <= 1'b0;
            grp   <= 4'h0;
            wd    <= 16'h0000;
            oe_n  <= 1'b1;
            rv    <= 1'b0;
            rd    <= 16'h0000;
            crdy  <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
            cs_n  <= next_cs_n;
            ds    <= next_ds;
            grp   <= next_grp;
            wd    <= next_wd;
            oe_n  <= next_oe_n;
            rv    <= next_rv;
            rd    <= next_rd;
            crdy  <= next_crdy;
        end
    end

    assign pins.port_select_n       = cs_n;
    assign pins.data_strobe_one     = ds;
    assign pins.data_strobe_two     = 1'b0;
    assign pins.access_select       = grp[3:2];
    assign pins.read_not_write      = grp[1];
    assign pins.halfword_select     = grp[0];
    assign pins.host_data_host_o    = wd;
    assign pins.host_data_host_oe_n = oe_n;
    assign cmd_ready = crdy;
    assign rsp_valid = rv;
    assign rsp_data  = rd;
endmodule // hph_host
`default_nettype wire

// ---- test/hph_asserts.sv ----
// Pin-level assertion checker for the host port handshake
`timescale 1ns/100ps
`default_nettype none
module hph_asserts
    import hph_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        port_select_n,
    input wire logic        data_strobe_one,
    input wire logic        data_strobe_two,
    input wire logic        port_ready_n,
    input wire logic [1:0]  access_select,
    input wire logic        read_not_write,
    input wire logic        halfword_select,
    input wire logic        host_data_dev_oe_n,
    input wire logic        host_data_host_oe_n,
    input wire logic [15:0] host_data_bus
);
    wire logic host_strobe;
    wire logic quiet_acc;
    wire logic busy_acc;

    assign host_strobe = port_select_n | ~(data_strobe_one ^ data_strobe_two);
    assign quiet_acc = access_select == SEL_CONTROL ||
                       access_select == SEL_ADDRESS ||
                       (access_select == SEL_WIN_FIXED && read_not_write &&
                        halfword_select);
    assign busy_acc = halfword_select && (access_select == SEL_WIN_INC ||
                      (access_select == SEL_WIN_FIXED && !read_not_write));

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_win_rd_first;
        $fell(host_strobe) && read_not_write && !halfword_select &&
        (access_select == SEL_WIN_INC || access_select == SEL_WIN_FIXED);
    endsequence
    sequence s_fetch_wait;
        ##[1:8] port_ready_n;
    endsequence

    a_ready_deselect: assert property (
        port_select_n && $past(port_select_n) |-> !port_ready_n)
        else $error("ready high while deselected");
    a_strobe_low_min: assert property (
        $fell(host_strobe) |-> !host_strobe [*4])
        else $error("strobe low pulse too short");
    a_strobe_high_min: assert property (
        $rose(host_strobe) |-> host_strobe [*4])
        else $error("strobe high gap too short");
    a_hold_for_ready: assert property (
        $rose(host_strobe) |-> !$past(port_ready_n))
        else $error("strobe released before ready low");
    a_group_stable: assert property (
        !host_strobe |->
        $stable({access_select, read_not_write, halfword_select}))
        else $error("select group moved under strobe");
    a_bus_one_driver: assert property (
        !host_data_dev_oe_n |-> host_data_host_oe_n && read_not_write)
        else $error("device drives bus outside a read");
    a_bus_read_window: assert property (
        $fell(host_data_dev_oe_n) |-> !host_strobe)
        else $error("device drives bus before strobe");
    a_data_before_ready: assert property (
        $fell(port_ready_n) && read_not_write && !port_select_n |->
        !host_data_dev_oe_n && $stable(host_data_bus))
        else $error("read data not settled at ready low");
    a_fetch_busy: assert property (
        s_win_rd_first |-> s_fetch_wait)
        else $error("no busy on window read fetch");
    a_quiet_access: assert property (
        $fell(host_strobe) && quiet_acc |-> !port_ready_n [*8])
        else $error("ready moved on a quiet access");
    a_second_half_busy: assert property (
        $rose(host_strobe) && $past(busy_acc) |->
        ##[1:8] (port_ready_n || port_select_n))
        else $error("no busy after second half");
endmodule // hph_asserts
`default_nettype wire

// ---- test/host_port_handshake_tb.sv ----
// Bench joining host and device ends across the host port pins
`timescale 1ns/100ps
`default_nettype none
module host_port_handshake_tb
    import hph_pkg::*;
    ;
    typedef struct packed {
        logic [1:0]  sel;
        logic        rd;
        logic        half;
        logic [15:0] wd;
        logic [15:0] exp;
        logic [1:0]  busy;
        logic        req;
    } hph_row_t;
    localparam hph_row_t ROWS [15] = '{
        '{SEL_ADDRESS,   1'b0, 1'b0, 16'h1230, 16'h0000, 2'h0, 1'b0},
        '{SEL_ADDRESS,   1'b0, 1'b1, 16'h0000, 16'h0000, 2'h0, 1'b0},
        '{SEL_ADDRESS,   1'b1, 1'b0, 16'h0000, 16'h1230, 2'h0, 1'b0},
        '{SEL_CONTROL,   1'b0, 1'b0, 16'h0005, 16'h0000, 2'h0, 1'b0},
        '{SEL_CONTROL,   1'b0, 1'b1, 16'h0005, 16'h0000, 2'h0, 1'b0},
        '{SEL_WIN_FIXED, 1'b0, 1'b0, 16'hBEEF, 16'h0000, 2'h0, 1'b0},
        '{SEL_WIN_FIXED, 1'b0, 1'b1, 16'hCAFE, 16'h0000, 2'h2, 1'b1},
        '{SEL_WIN_FIXED, 1'b1, 1'b0, 16'h0000, 16'hEDCF, 2'h1, 1'b1},
        '{SEL_WIN_FIXED, 1'b1, 1'b1, 16'h0000, 16'hFFFF, 2'h0, 1'b0},
        '{SEL_WIN_INC,   1'b1, 1'b0, 16'h0000, 16'hEDCF, 2'h1, 1'b1},
        '{SEL_WIN_INC,   1'b1, 1'b1, 16'h0000, 16'hFFFF, 2'h2, 1'b1},
        '{SEL_ADDRESS,   1'b1, 1'b0, 16'h0000, 16'h1234, 2'h0, 1'b0},
        '{SEL_WIN_INC,   1'b0, 1'b0, 16'h1111, 16'h0000, 2'h0, 1'b0},
        '{SEL_WIN_INC,   1'b0, 1'b1, 16'h2222, 16'h0000, 2'h2, 1'b1},
        '{SEL_ADDRESS,   1'b1, 1'b0, 16'h0000, 16'h1238, 2'h0, 1'b0}};

    logic        mclk;
    logic        rst;
    logic        cmd_valid;
    logic [1:0]  cmd_select;
    logic        cmd_read;
    logic        cmd_half;
    logic [15:0] cmd_wdata;
    logic        cmd_ready;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic        xfer_req;
    logic        xfer_write;
    logic [31:0] xfer_addr;
    logic [31:0] xfer_wdata;
    logic        xfer_done  = 1'b0;
    logic [31:0] xfer_rdata = 32'h00000000;
    logic        strap_endian;
    logic [1:0]  strap_boot;
    logic [15:0] control_word;
    logic [31:0] lw_addr    = 32'h00000000;
    logic [31:0] lw_data    = 32'h00000000;
    logic [15:0] rd_val;
    int          error_cnt  = 0;
    int          n_tests    = 0;
    int          busy_cnt   = 0;
    int          req_cnt    = 0;
    int          eng_cnt    = 0;
    int          eng_lat    = 3;
    int          b0;
    int          r0;

    hph_if pins ();
    hph_device i_hph_device (.mclk (mclk), .rst (rst), .pins (pins),
        .xfer_req (xfer_req), .xfer_write (xfer_write),
        .xfer_addr (xfer_addr), .xfer_wdata (xfer_wdata),
        .xfer_done (xfer_done), .xfer_rdata (xfer_rdata),
        .strap_endian (strap_endian), .strap_boot (strap_boot),
        .control_word (control_word));
    hph_host i_hph_host (.mclk (mclk), .rst (rst), .pins (pins),
        .cmd_valid (cmd_valid), .cmd_select (cmd_select),
        .cmd_read (cmd_read), .cmd_half (cmd_half),
        .cmd_wdata (cmd_wdata), .cmd_ready (cmd_ready),
        .rsp_valid (rsp_valid), .rsp_data (rsp_data));
    hph_asserts i_hph_asserts (.mclk (mclk), .rst (rst),
        .port_select_n (pins.port_select_n),
        .data_strobe_one (pins.data_strobe_one),
        .data_strobe_two (pins.data_strobe_two),
        .port_ready_n (pins.port_ready_n),
        .access_select (pins.access_select),
        .read_not_write (pins.read_not_write),
        .halfword_select (pins.halfword_select),
        .host_data_dev_oe_n (pins.host_data_dev_oe_n),
        .host_data_host_oe_n (pins.host_data_host_oe_n),
        .host_data_bus (pins.host_data_bus));

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Transfer engine stand-in and busy counter
    always @(posedge mclk)
    begin
        xfer_done <= 1'b0;
        if (eng_cnt == 1)
            xfer_done <= 1'b1;
        if (eng_cnt != 0)
            eng_cnt <= eng_cnt - 1;
        if (xfer_req === 1'b1)
        begin
            eng_cnt    <= eng_lat;
            xfer_rdata <= ~xfer_addr;
            req_cnt    <= req_cnt + 1;
            if (xfer_write === 1'b1)
            begin
                lw_addr <= xfer_addr;
                lw_data <= xfer_wdata;
            end
        end
        if (pins.port_select_n === 1'b0 && pins.port_ready_n === 1'b1)
            busy_cnt <= busy_cnt + 1;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_hi(input int which);
        int k;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while ((which ? rsp_valid : cmd_ready) !== 1'b1 && k < 300);
        if (k >= 300)
        begin
            error_cnt++;
            $display("[FAIL] handshake wait expected done seen timeout");
            end_sim();
        end
    endtask

    task automatic do_cmd(input logic [1:0] sel, input logic rd,
                          input logic half, input logic [15:0] wd,
                          output logic [15:0] rdat);
        rdat = 16'h0000;
        cmd_valid  <= 1'b1;
        cmd_select <= sel;
        cmd_read   <= rd;
        cmd_half   <= half;
        cmd_wdata  <= wd;
        wait_hi(0);
        cmd_valid  <= 1'b0;
        if (rd)
        begin
            wait_hi(1);
            rdat = rsp_data;
        end
        wait_hi(0);
    endtask

    initial
    begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_select = SEL_CONTROL;
        cmd_read = 1'b0;
        cmd_half = 1'b0;
        cmd_wdata = 16'h0000;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("ready_n", pins.port_ready_n, 1'b0);
        chk("dev_oe_n", pins.host_data_dev_oe_n, 1'b1);
        chk("strap_endian", strap_endian, 1'b0);
        chk("strap_boot", strap_boot, 2'h0);
        chk("control_word", control_word, CONTROL_RESET);
        $display("test reset done");
        for (int i = 0; i < 15; i++)
        begin
            b0 = busy_cnt;
            r0 = req_cnt;
            do_cmd(ROWS[i].sel, ROWS[i].rd, ROWS[i].half, ROWS[i].wd, rd_val);
            repeat (12) @(posedge mclk);
            if (ROWS[i].rd)
                chk("read data", rd_val, ROWS[i].exp);
            if (ROWS[i].busy != 2'h2)
                chk("busy", busy_cnt != b0, ROWS[i].busy[0]);
            chk("engine requests", req_cnt - r0, ROWS[i].req);
        end
        chk("control_word", control_word, 16'h0005);
        chk("write addr", lw_addr, 32'h00001234);
        chk("write data", lw_data, 32'h22221111);
        $display("test row table done");
        eng_lat = 40;
        do_cmd(SEL_WIN_FIXED, 1'b0, 1'b0, 16'h5555, rd_val);
        do_cmd(SEL_WIN_FIXED, 1'b0, 1'b1, 16'h6666, rd_val);
        b0 = busy_cnt;
        do_cmd(SEL_WIN_FIXED, 1'b0, 1'b0, 16'h7777, rd_val);
        chk("busy at select", busy_cnt > b0 + 20, 1'b1);
        do_cmd(SEL_WIN_FIXED, 1'b0, 1'b1, 16'h8888, rd_val);
        repeat (60) @(posedge mclk);
        chk("write addr", lw_addr, 32'h00001238);
        chk("write data", lw_data, 32'h88887777);
        $display("test pending busy done");
        end_sim();
    end
endmodule // host_port_handshake_tb
`default_nettype wire
